/* File: cias_regs.svh */
`ifndef CIAS_REGS_SVH
`define CIAS_REGS_SVH

`define CIAS_ADDR_W       32
`define CIAS_PAGE_BITS    11
`define CIAS_CROSS_BIT    11
`define CIAS_HIGH_LSB     24
`define CIAS_LIST_STEP    32'h00000004
`define CIAS_PAGE_MASK    32'h000007FF
`define CIAS_HIGH_MASK    32'hFF000000
`define CIAS_ZERO_ADDR    32'h00000000

`endif

/* File: cias_pkg.sv */
package cias_pkg;
  typedef enum logic [2:0] {
    CIAS_IDLE  = 3'b000,
    CIAS_FIRST = 3'b001,
    CIAS_XFER  = 3'b011,
    CIAS_NEXT  = 3'b010,
    CIAS_CHECK = 3'b110
  } cias_state_type;

  typedef struct packed {
    cias_state_type state;
    logic [31:0]    data_addr;
    logic [31:0]    list_ptr;
    logic           indirect;
    logic           backward;
    logic           fetch_req;
    logic [31:0]    fetch_addr;
    logic           prog_check;
    logic           busy;
  } cias_regs_type;
endpackage

/* File: cias_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cias_regs.svh"

// What this block does
// - Indirect flag set means command address points to the address list.
// - Transfer may stop after any byte, but not while a list word is fetched, leaving the last page partly used.
// - Page end is low eleven bits wrapping; direction picks wrap sense.
// - Later list words unaligned or with nonzero high byte cause program check.
// - Byte-multiplexer unit control word holds a fourth word, the list pointer.
// - On indirect entry store pointer, fetch first word as data address.
// - Compare bit 4 of byte 2 before and after update for crossings.
// - On crossing fetch next list word through the stored pointer.
// - Every chained command word has its indirect flag tested afresh.
// - Console printer uses the same indirect handling as the multiplexer.
// - Only start-I/O operations use indirect lists; maintenance stays untranslated.
// - Works in basic-control and extended-control modes alike.
module cias_sequencer (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_indirect_flag,
  input  wire logic        cmd_read_backward,
  input  wire logic        cmd_start_io,
  input  wire logic        cmd_extended_control_mode,
  input  wire logic [31:0] cmd_data_addr,
  input  wire logic        byte_step,
  input  wire logic        xfer_end,
  input  wire logic        mem_ready,
  input  wire logic [31:0] mem_rdata,
  output logic             cmd_ready,
  output logic             mem_req,
  output logic [31:0]      mem_addr,
  output logic [31:0]      data_addr,
  output logic             data_addr_valid,
  output logic [31:0]      unit_control_word_list_ptr,
  output logic             program_check,
  output logic             xfer_stall
);
  import cias_pkg::*;

  // ==========================================================
  // Sequencer state.

  // The whole sequencer state lives in one record so that reset and the
  // clocked update treat every field alike.
  cias_regs_type r;
  cias_regs_type next_r;

  // ==========================================================
  // Address arithmetic.

  // Later list words must start a page and carry nothing in the top byte.
  function automatic logic list_word_bad(input logic [31:0] w);
    logic misaligned;
    logic high_set;
    misaligned    = (w & `CIAS_PAGE_MASK) != `CIAS_ZERO_ADDR;
    high_set      = (w & `CIAS_HIGH_MASK) != `CIAS_ZERO_ADDR;
    list_word_bad = misaligned || high_set;
  endfunction

  // Moves the data address one byte in the direction of the transfer.
  function automatic logic [31:0] step_addr(
    input logic [31:0] addr,
    input logic        backward
  );
    if (backward) begin
      step_addr = addr - 32'h00000001;
    end else begin
      step_addr = addr + 32'h00000001;
    end
  endfunction

  // A change of the watched address bit means a page boundary was passed.
  // Watching one bit works in both directions, since a wrap of the low
  // page bits always flips the bit just above them.
  function automatic logic page_crossed(
    input logic [31:0] before_addr,
    input logic [31:0] after_addr
  );
    page_crossed = before_addr[`CIAS_CROSS_BIT] != after_addr[`CIAS_CROSS_BIT];
  endfunction

  // The list pointer moves on by one list word after every fetch.
  function automatic logic [31:0] advance_ptr(input logic [31:0] ptr);
    advance_ptr = ptr + `CIAS_LIST_STEP;
  endfunction

  // A fresh page is entered at its low end going forward and at its high
  // end going backward, so the first byte moved lies inside the new page.
  function automatic logic [31:0] page_entry(
    input logic [31:0] word,
    input logic        backward
  );
    if (backward) begin
      page_entry = word | `CIAS_PAGE_MASK;
    end else begin
      page_entry = word;
    end
  endfunction

  // ==========================================================
  // Command entry decode.

  // Maintenance alter and display never go through the list, whatever
  // the flag says, so the flag only counts under start I/O.
  // Both control modes behave alike, so the mode input selects nothing.
  logic        entry_indirect;
  logic [31:0] stepped_addr;
  logic        crossing;

  assign entry_indirect = cmd_indirect_flag && cmd_start_io;
  assign stepped_addr   = step_addr(r.data_addr, r.backward);
  assign crossing       = r.indirect && page_crossed(r.data_addr, stepped_addr);

  // ==========================================================
  // Next-state logic.
  always_comb begin
    next_r = r;
    case (r.state)
      // Idle: a command is taken and its flag decides the addressing.
      CIAS_IDLE: begin
        if (cmd_valid) begin
          next_r.backward   = cmd_read_backward;
          next_r.prog_check = 1'b0;
          next_r.busy       = 1'b1;
          if (entry_indirect) begin
            next_r.indirect   = 1'b1;
            next_r.list_ptr   = cmd_data_addr;
            next_r.fetch_addr = cmd_data_addr;
            next_r.fetch_req  = 1'b1;
            next_r.state      = CIAS_FIRST;
          end else begin
            next_r.indirect  = 1'b0;
            next_r.data_addr = cmd_data_addr;
            next_r.state     = CIAS_XFER;
          end
        end
      end
      // First list word: it may point anywhere inside a page.
      CIAS_FIRST: begin
        if (mem_ready) begin
          next_r.fetch_req = 1'b0;
          next_r.data_addr = mem_rdata;
          next_r.list_ptr  = advance_ptr(r.list_ptr);
          next_r.state     = CIAS_XFER;
        end
      end
      // Transfer: each byte moves the address; a crossing fetches the
      // next list word before any further byte is accepted.
      CIAS_XFER: begin
        if (xfer_end) begin
          next_r.busy  = 1'b0;
          next_r.state = CIAS_IDLE;
        end else if (byte_step) begin
          next_r.data_addr = stepped_addr;
          if (crossing) begin
            next_r.fetch_addr = r.list_ptr;
            next_r.fetch_req  = 1'b1;
            next_r.state      = CIAS_NEXT;
          end
        end
      end
      // Later list word: checked before it may become the data address.
      CIAS_NEXT: begin
        if (mem_ready) begin
          next_r.fetch_req = 1'b0;
          next_r.list_ptr  = advance_ptr(r.list_ptr);
          if (list_word_bad(mem_rdata)) begin
            next_r.prog_check = 1'b1;
            next_r.state      = CIAS_CHECK;
          end else begin
            next_r.data_addr = page_entry(mem_rdata, r.backward);
            next_r.state     = CIAS_XFER;
          end
        end
      end
      // Program check: the operation ends at once and the flag stays up
      // until the next command is taken.
      CIAS_CHECK: begin
        next_r.busy  = 1'b0;
        next_r.state = CIAS_IDLE;
      end
      // An unused state code falls back to idle.
      default: begin
        next_r.state = CIAS_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register.

  // Reset is synchronous; a command may follow on the first edge after
  // release, since idle is the reset state.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs; console printer and multiplexer share this path.

  // Handshake outputs follow the state directly.
  // The stall holds the data path while a list word is being fetched.
  assign cmd_ready                  = (r.state == CIAS_IDLE);
  assign data_addr_valid            = (r.state == CIAS_XFER);
  assign xfer_stall                 = r.busy && (r.state != CIAS_XFER);

  // Data outputs come straight from the registered state.
  assign mem_req                    = r.fetch_req;
  assign mem_addr                   = r.fetch_addr;
  assign data_addr                  = r.data_addr;
  assign unit_control_word_list_ptr = r.list_ptr;
  assign program_check              = r.prog_check;
endmodule // cias_sequencer

`default_nettype wire

/* File: cias_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cias_assertions (
  input wire logic        core_clk, rst_n, cmd_valid, cmd_indirect_flag, cmd_read_backward, cmd_start_io,
  input wire logic        cmd_extended_control_mode, byte_step, xfer_end, mem_ready, cmd_ready, mem_req,
  input wire logic        data_addr_valid, program_check, xfer_stall,
  input wire logic [31:0] cmd_data_addr, mem_rdata, mem_addr, data_addr, unit_control_word_list_ptr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic tk, ind, bw, seen;
  logic [31:0] nx;
  assign tk = cmd_valid && cmd_ready;
  assign nx = bw ? data_addr - 32'h1 : data_addr + 32'h1;
  // Seen marks that the first list word is in, so later fetches are judged strictly.
  always_ff @(posedge core_clk) begin
    if (tk) begin
      ind <= cmd_indirect_flag && cmd_start_io;
      bw  <= cmd_read_backward;
    end
    seen <= rst_n && !tk && (seen || data_addr_valid);
  end
  a_indirect_entry: assert property (tk && cmd_indirect_flag && cmd_start_io |=> mem_req
    && mem_addr == $past(cmd_data_addr) && unit_control_word_list_ptr == $past(cmd_data_addr)) else $error("bad entry");
  a_direct_addr: assert property (tk && !(cmd_indirect_flag && cmd_start_io) |=> data_addr_valid
    && data_addr == $past(cmd_data_addr)) else $error("bad direct");
  a_good_word: assert property (mem_req && mem_ready && mem_rdata[31:24] == 8'h00
    && (!seen || mem_rdata[10:0] == 11'h000) |=> data_addr_valid && unit_control_word_list_ptr == $past(mem_addr) + 32'h4
    && (data_addr & 32'hFFFFF800) == ($past(mem_rdata) & 32'hFFFFF800)) else $error("bad load");
  a_bad_word: assert property (seen && mem_req && mem_ready
    && (mem_rdata[31:24] != 8'h00 || mem_rdata[10:0] != 11'h000) |=> program_check ##1 cmd_ready) else $error("no check");
  a_page_cross: assert property (ind && data_addr_valid && byte_step && !xfer_end && nx[11] != data_addr[11]
    |=> mem_req && mem_addr == unit_control_word_list_ptr && !data_addr_valid && xfer_stall) else $error("no fetch");
  a_byte_step: assert property (data_addr_valid && byte_step && !xfer_end
    |=> data_addr == (bw ? $past(data_addr) - 32'h1 : $past(data_addr) + 32'h1)) else $error("bad step");
  a_end_idle: assert property (xfer_end && data_addr_valid |=> cmd_ready && !data_addr_valid) else $error("no stop");
  a_req_hold: assert property (mem_req && !mem_ready && !xfer_end |=> mem_req && $stable(mem_addr)) else $error("req");
  c_cross: cover property (seen && mem_req && mem_ready);
  c_bad: cover property (program_check);
  c_back: cover property (bw && ind && data_addr_valid);
endmodule // cias_assertions
`default_nettype wire

/* File: cias_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cias_mem_model (
  input  wire logic        core_clk, rst_n, mem_req, slow,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ready,
  output logic [31:0]      mem_rdata
);
  logic [31:0] list [0:3];
  logic [1:0]  cnt;
  wire logic   go = mem_req && !mem_ready && (!slow || cnt == 2'h2);
  // Outside an answer the read data toggles so a stale word is never mistaken for a fresh one.
  always_ff @(posedge core_clk) begin
    cnt       <= rst_n && mem_req && !mem_ready ? cnt + 2'h1 : 2'h0;
    mem_ready <= rst_n && go;
    mem_rdata <= go ? list[mem_addr[3:2]] : ~mem_rdata;
  end
endmodule // cias_mem_model
`default_nettype wire

/* File: cias_sequencer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module cias_sequencer_test;
  logic core_clk = 0, rst_n = 0, cmd_valid = 0, cmd_indirect_flag = 0, cmd_read_backward = 0, cmd_start_io = 0;
  logic cmd_extended_control_mode = 0, byte_step = 0, xfer_end = 0, slow = 0, mem_ready, cmd_ready, mem_req;
  logic data_addr_valid, program_check, xfer_stall;
  logic [31:0] cmd_data_addr = 0, mem_rdata, mem_addr, data_addr, unit_control_word_list_ptr;
  int errors = 0, tests_run = 0, cyc = 0;
  cias_sequencer dut (.*);
  cias_mem_model mem (.*);
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 2000) begin errors++; report_and_stop; end
  task automatic chk(string s, logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin errors++; $display("CHECK FAILED %s exp %h got %h", s, e, g); end
  endtask
  task automatic wt;
    for (int i = 0; i < 9 && data_addr_valid !== 1'b1; i++) @(posedge core_clk) #1;
  endtask
  task automatic cmd(logic f, b, s, logic [31:0] a);
    @(posedge core_clk) #1 {cmd_valid, cmd_indirect_flag, cmd_read_backward, cmd_start_io, cmd_data_addr} = {1'b1, f, b, s, a};
    @(posedge core_clk) #1 cmd_valid = 0;
    wt;
  endtask
  task automatic step(int n);
    repeat (n) begin wt; byte_step = 1; @(posedge core_clk) #1 byte_step = 0; @(posedge core_clk) #1; end
  endtask
  task automatic end_x;
    xfer_end = 1;
    @(posedge core_clk) #1 xfer_end = 0;
    chk("cmd_ready", 1, cmd_ready);
  endtask
  task automatic t_direct;
    for (int i = 0; i < 2; i++) begin
      cmd_extended_control_mode = i[0];
      cmd(!i[0], 0, i[0], 32'h7FF);
      chk("direct_addr", 32'h7FF, data_addr);
      step(1);
      chk("direct_step", 32'h800, data_addr);
      chk("no_fetch", 0, mem_req);
      end_x;
    end
  endtask
  task automatic t_ind(logic b, logic [31:0] a, w);
    mem.list[0] = a;
    mem.list[1] = w;
    cmd(1, b, 1, 32'h100);
    chk("first_word", a, data_addr);
    chk("list_ptr", 32'h104, unit_control_word_list_ptr);
    step(2);
    chk("stall", 1, xfer_stall);
    wt;
    if (w[10:0] != 0 || w[31:24] != 0) chk("prog_check", 1, program_check);
    else begin
      chk("next_page", b ? w | 32'h7FF : w, data_addr);
      chk("list_ptr2", 32'h108, unit_control_word_list_ptr);
    end
    end_x;
  endtask
  task automatic report_and_stop;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1;
    chk("reset_ready", 1, cmd_ready);
    chk("reset_req", 0, mem_req);
    t_direct;
    t_ind(0, 32'h17FE, 32'h3000);
    slow = 1;
    t_ind(1, 32'h1001, 32'h3000);
    t_ind(0, 32'h17FE, 32'h3004);
    t_ind(0, 32'h17FE, 32'h01003000);
    report_and_stop;
  end
endmodule // cias_sequencer_test
bind cias_sequencer cias_assertions chk (.*);
`default_nettype wire
